// ===== rnb_params.svh
// Purpose: shared constants for the nibble bus clock port
// Assumes: 125 MHz system clock
// Notes:   times in their own unit, cycle counts derived
`ifndef RNB_PARAMS_SVH
`define RNB_PARAMS_SVH
`define RNB_CLK_HZ          125000000
`define RNB_OSC_HZ_X1000    32768000
`define RNB_OSC_DIV         ((`RNB_CLK_HZ * 64'd1000) / `RNB_OSC_HZ_X1000)
`define RNB_TICKS_PER_SEC   32768
`define RNB_BUSY_LOW_TICKS  16
`define RNB_FIRST_FALL_US   1000122
`define RNB_FIRST_FALL_TICKS 32772
`define RNB_HOLDOFF_US      244
`define RNB_HOLDOFF_CYC     (`RNB_HOLDOFF_US * (`RNB_CLK_HZ / 1000000))
`define RNB_ADDR_DIV_RESET  4'hD
`define RNB_ADDR_REF_LO     4'hE
`define RNB_DIGITS          13
`define RNB_HOST_STEP_CYC   8
`endif

// ===== rnb_pkg.sv
// Purpose: types shared by both ends
// Assumes: nothing
// Notes:   host sequencer states
package rnb_pkg;
  typedef logic [3:0] rnb_nibble_t;
  typedef enum logic [2:0] {
    RNB_IDLE,
    RNB_ALOAD,
    RNB_STROBE,
    RNB_CHECK,
    RNB_DONE
  } rnb_host_state_t;
endpackage

// ===== rnb_if.sv
// Purpose: wires between host and clock device
// Assumes: open-drain nibble bus and busy line, pull-ups resolved here
// Notes:   oe low with o low means driving low
interface rnb_if;
  logic       supply_side_select;
  logic       host_side_select;
  logic       addr_load;
  logic       write_strobe;
  logic       read_strobe;
  logic       stop;
  logic       test;
  logic [3:0] host_bus_o;
  logic [3:0] host_bus_oe_n;
  logic [3:0] dev_bus_o;
  logic [3:0] dev_bus_oe_n;
  logic       busy_n_o;
  logic       busy_n_oe_n;
  logic [3:0] nibble_bus;
  logic       busy_n;
  // Pull-up: a line is low only when some driver enables a low
  genvar i;
  for (i = 0; i < 4; i++) begin : g_bus
    assign nibble_bus[i] = !((!host_bus_oe_n[i] && !host_bus_o[i]) ||
                             (!dev_bus_oe_n[i] && !dev_bus_o[i]));
  end
  assign busy_n = !(!busy_n_oe_n && !busy_n_o);
  modport host (
    output supply_side_select, host_side_select, addr_load, write_strobe,
    output read_strobe, stop, test, host_bus_o, host_bus_oe_n,
    input  nibble_bus, busy_n
  );
  modport dev (
    input  supply_side_select, host_side_select, addr_load, write_strobe,
    input  read_strobe, stop, test, nibble_bus,
    output dev_bus_o, dev_bus_oe_n, busy_n_o, busy_n_oe_n
  );
endinterface

// ===== rnb_host.sv
// Purpose: microcontroller end, one digit read or write per request
// Assumes: device on the other side of rnb_if
// Notes:   reads repeat until two agree unless stopped
`include "rnb_params.svh"
module rnb_host
  import rnb_pkg::*;
#(
  parameter int STEP_CYC = `RNB_HOST_STEP_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic        req_i,
  input  wire logic        wr_i,
  input  wire logic        freeze_i,
  input  wire logic [3:0]  digit_i,
  input  wire logic [3:0]  wdata_i,
  output logic             done_o,
  output logic [3:0]       rdata_o,
  rnb_if.host              bus
);
  rnb_host_state_t state;
  logic [15:0] step;
  logic [3:0]  last, ad, wd, s1, s2;
  logic        have, isw, b1, b2;

  // Pins from the other side pass two flops
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1 <= 4'hF;
      s2 <= 4'hF;
      b1 <= 1'b1;
      b2 <= 1'b1;
    end else begin
      s1 <= bus.nibble_bus;
      s2 <= s1;
      b1 <= bus.busy_n;
      b2 <= b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= RNB_IDLE;
      step  <= 16'h0000;
      last  <= 4'h0;
      have  <= 1'b0;
      isw   <= 1'b0;
      ad    <= 4'h0;
      wd    <= 4'h0;
      done_o <= 1'b0;
      rdata_o <= 4'h0;
    end else begin
      done_o <= 1'b0;
      case (state)
        RNB_IDLE: begin
          if (req_i) begin
            ad <= digit_i;
            wd <= wdata_i;
            isw <= wr_i;
            have <= 1'b0;
            step <= 16'h0000;
            state <= RNB_ALOAD;
          end
        end
        RNB_ALOAD: begin
          step <= step + 16'h0001;
          if (step == 16'(STEP_CYC - 1)) begin
            step <= 16'h0000;
            state <= RNB_STROBE;
          end
        end
        RNB_STROBE: begin
          step <= step + 16'h0001;
          if (step == 16'(STEP_CYC - 1)) begin
            step <= 16'h0000;
            state <= isw ? RNB_DONE : RNB_CHECK;
          end
        end
        RNB_CHECK: begin
          have <= 1'b1;
          last <= s2;
          if (freeze_i || (have && last == s2)) begin
            rdata_o <= s2;
            state <= RNB_DONE;
          end else begin
            state <= b2 ? RNB_STROBE : RNB_CHECK;
          end
        end
        default: begin
          done_o <= 1'b1;
          state <= RNB_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bus.supply_side_select <= 1'b0;
      bus.host_side_select   <= 1'b0;
      bus.addr_load          <= 1'b0;
      bus.write_strobe       <= 1'b0;
      bus.read_strobe        <= 1'b0;
      bus.stop               <= 1'b0;
      bus.test               <= 1'b0;
      bus.host_bus_o         <= 4'hF;
      bus.host_bus_oe_n      <= 4'hF;
    end else begin
      bus.supply_side_select <= 1'b1;
      // stay selected while frozen so stop is heard
      bus.host_side_select   <= (state != RNB_IDLE) || freeze_i;
      bus.stop               <= freeze_i;
      bus.addr_load          <= (state == RNB_ALOAD);
      bus.write_strobe       <= (state == RNB_STROBE) && isw;
      bus.read_strobe        <= (state == RNB_STROBE) && !isw;
      bus.host_bus_o         <= (state == RNB_ALOAD) ? ad : wd;
      bus.host_bus_oe_n      <= (state == RNB_ALOAD || (state == RNB_STROBE && isw))
                                ? 4'h0 : 4'hF;
    end
  end
endmodule

// ===== rnb_dev.sv
// How it works
// - Access only with both selects high
// - Deselected: ignore inputs, release data pins
// - Write level loads digit continuously
// - Host latches address, then reads
// - Host reads while busy high
// - Read allowed within 244 us of busy falling, then suspended
// - Stop high halts counting, reads valid
// - Host may accept two matching reads
// - Address load level latches nibble
// - Data pins open drain, pull low only
// - Busy open drain, 1 Hz, ignores selects
// - Divider reset code suspends busy
// - After divider reset, first fall ~1000.1221 ms
// - Write held off once busy has been low 244 us
//
// Purpose: clock device end of the nibble bus, digit store and busy timer
// Assumes: 32.768 kHz time base made by dividing mclk_i
// Notes:   digits are plain storage; calendar counting lives elsewhere
`include "rnb_params.svh"
module rnb_dev
  import rnb_pkg::*;
#(
  parameter int OSC_DIV  = int'(`RNB_OSC_DIV),
  parameter int SEC_TICK = `RNB_TICKS_PER_SEC,
  parameter int HOLD_CYC = `RNB_HOLDOFF_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  output logic             sec_pulse_o,
  rnb_if.dev               bus
);
  // first period a few ticks longer than a second
  localparam int FIRST_TICK = SEC_TICK + `RNB_FIRST_FALL_TICKS - `RNB_TICKS_PER_SEC;
  rnb_nibble_t digit [`RNB_DIGITS];
  logic [8:0]  s_b;
  logic [3:0]  d_b;
  logic [3:0]  addr;
  logic [15:0] osc_cnt;
  logic [15:0] tick;
  logic [31:0] hold;
  logic        osc_en, busy_low, sel, divrst, first, gate;
  logic        halt, wrap;

  rnb_sync2 #(
    .W   (9),
    .RST (9'h000)
  ) rnb_sync2_ctl_inst (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .d_i    ({bus.supply_side_select, bus.host_side_select, bus.addr_load,
              bus.write_strobe, bus.read_strobe, bus.stop, bus.test, 2'b00}),
    .q_o    (s_b)
  );

  // data pins idle high, so reset to high
  rnb_sync2 #(
    .W   (4),
    .RST (4'hF)
  ) rnb_sync2_data_inst (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .d_i    (bus.nibble_bus),
    .q_o    (d_b)
  );

  assign sel    = s_b[8] && s_b[7];
  assign divrst = sel && s_b[5] && addr == `RNB_ADDR_DIV_RESET;
  assign gate   = !busy_low || hold != 32'h0;
  assign halt   = sel && s_b[3];
  assign wrap   = osc_en && (first ? tick == 16'(FIRST_TICK - 1)
                                   : tick == 16'(SEC_TICK - 1));

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      osc_cnt <= 16'h0000;
      osc_en  <= 1'b0;
    end else begin
      osc_en  <= (osc_cnt == 16'(OSC_DIV - 1));
      osc_cnt <= (osc_cnt == 16'(OSC_DIV - 1)) ? 16'h0000 : osc_cnt + 16'h0001;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i)
      tick <= 16'h0000;
    else if (divrst || wrap)
      tick <= 16'h0000;
    else if (osc_en)
      tick <= tick + 16'h0001;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i)
      first <= 1'b0;
    else if (divrst)
      first <= 1'b1;
    else if (wrap)
      first <= 1'b0;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i)
      busy_low <= 1'b0;
    else if (divrst)
      busy_low <= 1'b0;
    else if (wrap)
      busy_low <= 1'b1;
    else if (osc_en && !first && tick == 16'(`RNB_BUSY_LOW_TICKS - 1))
      busy_low <= 1'b0;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i)
      sec_pulse_o <= 1'b0;
    else
      sec_pulse_o <= wrap && !divrst && !halt;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i)
      hold <= 32'h0;
    else if (!busy_low)
      hold <= 32'(HOLD_CYC);
    else if (hold != 32'h0)
      hold <= hold - 32'h1;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i)
      addr <= 4'h0;
    else if (sel && s_b[6])
      addr <= d_b;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < `RNB_DIGITS; i++)
        digit[i] <= 4'h0;
    end else if (sel && s_b[5] && (gate || halt) && addr < 4'(`RNB_DIGITS)) begin
      digit[addr] <= d_b;
    end
  end

  // open drain data, released when deselected
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bus.dev_bus_o    <= 4'hF;
      bus.dev_bus_oe_n <= 4'hF;
    end else if (sel && s_b[4] && !s_b[5] && (gate || halt)
                 && addr < 4'(`RNB_DIGITS)) begin
      bus.dev_bus_o    <= 4'h0;
      bus.dev_bus_oe_n <= digit[addr];
    end else if (!sel || !s_b[4]) begin
      bus.dev_bus_o    <= 4'hF;
      bus.dev_bus_oe_n <= 4'hF;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bus.busy_n_o    <= 1'b0;
      bus.busy_n_oe_n <= 1'b1;
    end else begin
      bus.busy_n_o    <= 1'b0;
      bus.busy_n_oe_n <= !busy_low;
    end
  end
endmodule

// Two-flop synchroniser for a group of pins
module rnb_sync2 #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         mclk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  // First stage may go metastable, only q_o is read
  logic [W-1:0] meta;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= RST;
      q_o  <= RST;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

// ===== rnb_asserts.sv
// Purpose: bus and busy rules watched on the wires between both ends
// Assumes: bench builds the device with OSC_DIV=2, SEC_TICK=64
// Notes:   busy period 128 cycles, low 32; address latch mirrored here
module rnb_asserts (
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  input  wire logic       supply_side_select,
  input  wire logic       host_side_select,
  input  wire logic       addr_load,
  input  wire logic       write_strobe,
  input  wire logic       read_strobe,
  input  wire logic [3:0] nibble_bus,
  input  wire logic [3:0] dev_bus_o,
  input  wire logic [3:0] dev_bus_oe_n,
  input  wire logic       busy_n_o,
  input  wire logic       busy_n_oe_n,
  input  wire logic       busy_n
);
  logic [3:0] addr_q;
  logic       sel;
  logic       dres;
  assign sel  = supply_side_select && host_side_select;
  assign dres = sel && write_strobe && (addr_q == 4'hD);
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_q <= 4'h0;
    end else if (sel && addr_load) begin
      addr_q <= nibble_bus;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  chk_desel_release: assert property (disable iff (!rstn_i) !sel [*4] |-> &dev_bus_oe_n)
    else $error("data pins driven while deselected");
  chk_pull_low_only: assert property (disable iff (!rstn_i) (~dev_bus_oe_n & dev_bus_o) == 4'h0)
    else $error("data pin driven high");
  chk_busy_od: assert property (disable iff (!rstn_i) busy_n_oe_n || !busy_n_o)
    else $error("busy driven high");
  chk_idle_release: assert property (disable iff (!rstn_i) !read_strobe [*4] |-> &dev_bus_oe_n)
    else $error("data pins driven without read");
  chk_busy_width: assert property (disable iff (!rstn_i || write_strobe)
    $fell(busy_n) |-> !busy_n [*8] ##[20:28] busy_n)
    else $error("busy low width wrong");
  chk_busy_period: assert property (disable iff (!rstn_i || write_strobe)
    $fell(busy_n) |-> ##[124:132] $fell(busy_n))
    else $error("busy period wrong");
  chk_dres_hold: assert property (disable iff (!rstn_i) dres [*5] |-> busy_n)
    else $error("busy low during divider reset");
  chk_dres_after: assert property (disable iff (!rstn_i) $fell(dres) |-> busy_n [*8])
    else $error("busy fell soon after divider reset");
endmodule

// ===== test_rtc_nibble_bus_interface.sv
// Purpose: both ends joined, digit writes, reads and busy timing checked
// Assumes: shortened divider OSC_DIV=2, SEC_TICK=64, HOLD_CYC=4
// Notes:   one busy period is 128 cycles with these values
module test_rtc_nibble_bus_interface;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk_i = 1'b0;
  logic       rstn_i = 1'b0;
  logic       req_i = 1'b0;
  logic       wr_i = 1'b0;
  logic       freeze_i = 1'b1;
  logic [3:0] digit_i = 4'h0;
  logic [3:0] wdata_i = 4'h0;
  logic       done_o;
  logic [3:0] rdata_o;
  logic       sec_pulse_o;
  int         miscompares = 0;
  int         n_compared = 0;
  int         cycles = 0;
  int         secs = 0;
  int         n_wait = 0;
  rnb_if bus ();
  rnb_host rnb_host_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .req_i(req_i), .wr_i(wr_i),
    .freeze_i(freeze_i), .digit_i(digit_i), .wdata_i(wdata_i), .done_o(done_o),
    .rdata_o(rdata_o), .bus(bus.host));
  rnb_dev #(.OSC_DIV(2), .SEC_TICK(64), .HOLD_CYC(4)) rnb_dev_inst (.mclk_i(mclk_i),
    .rstn_i(rstn_i), .sec_pulse_o(sec_pulse_o), .bus(bus.dev));
  rnb_asserts rnb_asserts_inst (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .supply_side_select(bus.supply_side_select), .host_side_select(bus.host_side_select),
    .addr_load(bus.addr_load), .write_strobe(bus.write_strobe),
    .read_strobe(bus.read_strobe), .nibble_bus(bus.nibble_bus), .dev_bus_o(bus.dev_bus_o),
    .dev_bus_oe_n(bus.dev_bus_oe_n), .busy_n_o(bus.busy_n_o),
    .busy_n_oe_n(bus.busy_n_oe_n), .busy_n(bus.busy_n));
  always #4 mclk_i = ~mclk_i;
  task automatic conclude();
    $display("Compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cycles++;
    if (sec_pulse_o === 1'b1) begin
      secs++;
    end
    // Generous ceiling, the whole sequence needs under 8000 cycles
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [3:0] d, input logic [3:0] v);
    int n;
    @(posedge mclk_i);
    req_i <= 1'b1;
    wr_i <= w;
    digit_i <= d;
    wdata_i <= v;
    @(posedge mclk_i);
    req_i <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk_i);
      #1;
      n++;
    end while (done_o !== 1'b1 && n < 2000);
    chk4({3'h0, done_o}, 4'h1);
  endtask
  task automatic count_secs(input int len, input logic [3:0] exp);
    int s0;
    repeat (8) @(posedge mclk_i);
    #1;
    s0 = secs;
    repeat (len) @(posedge mclk_i);
    #1;
    chk4(4'(secs - s0), exp);
  endtask
  initial begin
    repeat (2) @(posedge mclk_i);
    rstn_i <= 1'b1;
    for (int d = 0; d < 13; d++) begin
      xfer(1'b1, 4'(d), 4'(d) ^ 4'hA);
    end
    for (int d = 0; d < 13; d++) begin
      xfer(1'b0, 4'(d), 4'h0);
      chk4(rdata_o, 4'(d) ^ 4'hA);
    end
    // Nothing stored or driven past the last digit, pull-ups read high
    xfer(1'b1, 4'hE, 4'h0);
    xfer(1'b0, 4'hE, 4'h0);
    chk4(rdata_o, 4'hF);
    count_secs(256, 4'h0);
    freeze_i <= 1'b0;
    count_secs(512, 4'h4);
    // Start just after busy rises so the write is not held off
    @(posedge bus.busy_n);
    xfer(1'b1, 4'h5, 4'h3);
    xfer(1'b0, 4'h5, 4'h0);
    chk4(rdata_o, 4'h3);
    // Write deep inside busy low is held off and lost
    @(negedge bus.busy_n);
    xfer(1'b1, 4'h6, 4'h9);
    @(posedge mclk_i);
    freeze_i <= 1'b1;
    xfer(1'b0, 4'h6, 4'h0);
    chk4(rdata_o, 4'hC);
    xfer(1'b1, 4'hD, 4'h0);
    // First fall 68 ticks of 2 cycles later, plus sync latency
    do begin
      @(posedge mclk_i);
      #1;
      n_wait++;
    end while (bus.busy_n !== 1'b0 && n_wait < 1000);
    chk4({3'h0, (n_wait >= 132 && n_wait <= 148)}, 4'h1);
    count_secs(1024, 4'h0);
    conclude();
  end
endmodule
